/* src/hpl_pkg.sv */
// package of constants and types for the pll ratio and lock control
package hpl_pkg;
	// timing source selection
	localparam logic [1:0] SRC_AUTO     = 2'h0;
	localparam logic [1:0] SRC_INTERNAL = 2'h1;
	localparam logic [1:0] SRC_EXTERNAL = 2'h2;
	// external reference divider encodings
	localparam logic [1:0] DIV_BY_ONE  = 2'h2;
	localparam logic [1:0] DIV_BY_TWO  = 2'h1;
	localparam logic [1:0] DIV_BY_FOUR = 2'h0;
	// ratio formats
	localparam logic FMT_HIGH_RES  = 1'h0;
	localparam logic FMT_HIGH_MULT = 1'h1;
	// modifier codes
	localparam logic [2:0] MOD_NONE  = 3'h0;
	localparam logic [2:0] MOD_MUL2  = 3'h1;
	localparam logic [2:0] MOD_MUL4  = 3'h2;
	localparam logic [2:0] MOD_MUL8  = 3'h3;
	localparam logic [2:0] MOD_DIV2  = 3'h4;
	localparam logic [2:0] MOD_DIV4  = 3'h5;
	localparam logic [2:0] MOD_DIV8  = 3'h6;
	localparam logic [2:0] MOD_DIV16 = 3'h7;
	// ratio field positions and widths
	localparam int RATIO_WIDTH     = 32;
	localparam int FRAC_HIGH_RES   = 20;
	localparam int FRAC_HIGH_MULT  = 12;
	localparam int EFF_INT_WIDTH   = 20;
	localparam int EFF_FRAC_WIDTH  = 20;
	// values after reset
	localparam logic [1:0]  RESET_SOURCE = SRC_AUTO;
	localparam logic [1:0]  RESET_DIVIDE = DIV_BY_ONE;
	localparam logic [39:0] RESET_RATIO  = 40'h0;
	// synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;

	typedef enum logic [1:0] {HPL_SRC_OSC, HPL_SRC_XTAL, HPL_SRC_REFCLK} hpl_source_type;
	typedef enum logic [1:0] {HPL_OFF, HPL_RUN, HPL_BLOCKED} hpl_state_type;
endpackage

/* src/hpl_cfg_if.sv */
// interface carrying effective ratio and its validity from the ratio unit
`timescale 1ns/10ps
interface hpl_cfg_if;
	logic [39:0] effRatio;
	logic        ratioValid;
	logic [31:0] rawRatio;
	logic        ratioFormat;
	logic [2:0]  modifier;
	modport producer (input rawRatio, input ratioFormat, input modifier, output effRatio, output ratioValid);
	modport consumer (output rawRatio, output ratioFormat, output modifier, input effRatio, input ratioValid);
endinterface

/* src/hpl_ratio_unit.sv */
// effective ratio computation with format, modifier and truncation
`timescale 1ns/10ps
module hpl_ratio_unit
	import hpl_pkg::*;
(
	// clock and reset
	input  wire logic clk,
	input  wire logic rstn,
	// ratio link
	hpl_cfg_if.producer cfg
);
	typedef struct packed {
		logic [39:0] effRatio;
		logic        ratioValid;
	} hpl_ratio_state_type;

	hpl_ratio_state_type state;
	hpl_ratio_state_type next_state;
	logic [63:0] wide;
	logic [63:0] shifted;

	always_comb begin
		wide = 64'h0;
		shifted = 64'h0;
		next_state = state;
		// align to 20 integer and 20 fraction bits
		if (cfg.ratioFormat == FMT_HIGH_RES) begin
			wide = {12'h0, cfg.rawRatio, 20'h0} >> FRAC_HIGH_RES;
		end else begin
			wide = {12'h0, cfg.rawRatio, 20'h0} >> FRAC_HIGH_MULT;
		end
		case (cfg.modifier)
			MOD_MUL2:  shifted = wide << 1;
			MOD_MUL4:  shifted = wide << 2;
			MOD_MUL8:  shifted = wide << 3;
			MOD_DIV2:  shifted = wide >> 1;
			MOD_DIV4:  shifted = wide >> 2;
			MOD_DIV8:  shifted = wide >> 3;
			MOD_DIV16: shifted = wide >> 4;
			default:   shifted = wide;
		endcase
		// drop bits beyond max factor and finer than min step
		next_state.effRatio = shifted[39:0];
		next_state.ratioValid = (shifted[39:0] != 40'h0);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= '{effRatio: RESET_RATIO, ratioValid: 1'b0};
		end else begin
			state <= next_state;
		end
	end

	assign cfg.effRatio = state.effRatio;
	assign cfg.ratioValid = state.ratioValid;
endmodule

/* src/hpl_control.sv */
// Functional notes
// - timing reference comes from reference clock pin, crystal or internal oscillator
// - auto source from pin straps unless software forces internal or external
// - divider code 10 is /1, 01 is /2, 00 is /4, with gear drive bit
// - loop runs only while both enable bits are set, any order
// - lock-loss flag reads 1 if lock lost since last read, cleared by read
// - flag reading 0 means locked throughout since last read
// - output frequency is input frequency times the ratio
// - frequency loop keeps tracking to hold the programmed ratio
// - 32-bit ratio with format bit choosing 12.20 or 20.12
// - high-resolution format has 12 integer and 20 fraction bits
// - high-multiplication format has 20 integer and 12 fraction bits
// - modifier multiplies by 2, 4, 8 or divides by 2, 4, 8, 16
// - effective ratio truncated to max factor and min step
// - invalid ratio disables output until a valid one results
// - clock input or configuration changes count as lock loss (code: counted only while running)
`timescale 1ns/10ps
module hpl_control
	import hpl_pkg::*;
(
	// clock and reset
	input  wire logic             clk,
	input  wire logic             rstn,
	// source and divider configuration
	input  wire logic [1:0]       timing_source_select,
	input  wire logic [1:0]       refDivide,
	input  wire logic             crystal_drive_gear_one,
	input  wire logic             crystal_drive_gear_two,
	input  wire logic             crystal_drive_gear_three,
	// pin connection sense
	input  wire logic             refPinTied,
	input  wire logic             crystalPinTied,
	// loop enables
	input  wire logic             loop_enable_first,
	input  wire logic             loop_enable_second,
	// ratio configuration
	input  wire logic [31:0]      ratio,
	input  wire logic             ratioFormat,
	input  wire logic [2:0]       multiplier_modifier,
	// analog lock indication and clock input presence, asynchronous
	input  wire logic             analogLocked,
	input  wire logic             clockInActive,
	// status read strobe
	input  wire logic             unlockRead,
	// status outputs
	output logic                  unlockFlag,
	// analog controls
	output hpl_source_type        activeSource,
	output logic [1:0]            dividerSetting,
	output logic                  crystalDrive,
	output logic                  loopEnable,
	output logic [39:0]           loopRatio,
	output logic                  outputEnable
);
	import hpl_pkg::*;

	// whole block state, registered once per clock
	typedef struct packed {
		logic [SYNC_STAGES-1:0] lockSync;
		logic [SYNC_STAGES-1:0] inSync;
		logic [SYNC_STAGES-1:0] refSync;
		logic [SYNC_STAGES-1:0] xtalSync;
		logic                   lockState;
		logic                   inState;
		logic                   refState;
		logic                   xtalState;
		logic                   flag;
		hpl_source_type         source;
		logic [1:0]             divider;
		logic                   drive;
		logic                   enable;
		logic [39:0]            ratioOut;
		logic                   outEn;
		logic [31:0]            lastRatio;
		logic                   lastFormat;
		logic [2:0]             lastModifier;
		logic [1:0]             lastDivide;
		logic [1:0]             lastSource;
		hpl_state_type          mode;
	} hpl_ctrl_state_type;

	hpl_ctrl_state_type state;
	hpl_ctrl_state_type next_state;
	logic               lossEvent;
	logic               cfgChange;
	logic               lockDrop;
	logic               clockDrop;

	// link to the ratio unit
	hpl_cfg_if cfg ();

	assign cfg.rawRatio = ratio;
	assign cfg.ratioFormat = ratioFormat;
	assign cfg.modifier = multiplier_modifier;

	hpl_ratio_unit ratioUnit (
		.clk  (clk),
		.rstn (rstn),
		.cfg  (cfg)
	);

	always_comb begin
		next_state = state;
		lossEvent = 1'b0;
		cfgChange = 1'b0;
		lockDrop = 1'b0;
		clockDrop = 1'b0;
		// three stage synchronisers, change counts when stages two and three agree
		next_state.lockSync = {state.lockSync[SYNC_STAGES-2:0], analogLocked};
		next_state.inSync = {state.inSync[SYNC_STAGES-2:0], clockInActive};
		if (state.lockSync[2] == state.lockSync[1]) begin
			next_state.lockState = state.lockSync[2];
		end
		if (state.inSync[2] == state.inSync[1]) begin
			next_state.inState = state.inSync[2];
		end
		// pin strap synchronisers
		next_state.refSync = {state.refSync[SYNC_STAGES-2:0], refPinTied};
		next_state.xtalSync = {state.xtalSync[SYNC_STAGES-2:0], crystalPinTied};
		if (state.refSync[2] == state.refSync[1]) begin
			next_state.refState = state.refSync[2];
		end
		if (state.xtalSync[2] == state.xtalSync[1]) begin
			next_state.xtalState = state.xtalSync[2];
		end
		// source choice
		case (timing_source_select)
			SRC_INTERNAL: next_state.source = HPL_SRC_OSC;
			SRC_EXTERNAL: next_state.source = state.xtalState ? HPL_SRC_XTAL : HPL_SRC_REFCLK;
			default: begin
				if (state.refState) begin
					next_state.source = HPL_SRC_OSC;
				end else if (state.xtalState) begin
					next_state.source = HPL_SRC_XTAL;
				end else begin
					next_state.source = HPL_SRC_REFCLK;
				end
			end
		endcase
		// divider and matching crystal gear
		next_state.divider = refDivide;
		case (refDivide)
			DIV_BY_ONE:  next_state.drive = crystal_drive_gear_one;
			DIV_BY_TWO:  next_state.drive = crystal_drive_gear_two;
			DIV_BY_FOUR: next_state.drive = crystal_drive_gear_three;
			default:     next_state.drive = 1'b0;
		endcase
		// configuration change tracking
		next_state.lastRatio = ratio;
		next_state.lastFormat = ratioFormat;
		next_state.lastModifier = multiplier_modifier;
		next_state.lastDivide = refDivide;
		next_state.lastSource = timing_source_select;
		cfgChange = (ratio != state.lastRatio) || (ratioFormat != state.lastFormat)
			|| (multiplier_modifier != state.lastModifier) || (refDivide != state.lastDivide)
			|| (timing_source_select != state.lastSource);
		// loop state
		next_state.enable = loop_enable_first && loop_enable_second;
		case (state.mode)
			HPL_OFF: begin
				if (next_state.enable) begin
					next_state.mode = cfg.ratioValid ? HPL_RUN : HPL_BLOCKED;
				end
			end
			HPL_RUN: begin
				if (!next_state.enable) begin
					next_state.mode = HPL_OFF;
				end else if (!cfg.ratioValid) begin
					next_state.mode = HPL_BLOCKED;
				end
			end
			default: begin
				if (!next_state.enable) begin
					next_state.mode = HPL_OFF;
				end else if (cfg.ratioValid) begin
					next_state.mode = HPL_RUN;
				end
			end
		endcase
		next_state.ratioOut = cfg.effRatio;
		next_state.outEn = (next_state.mode == HPL_RUN);
		// lock loss: analog unlock, clock input drop, or config change while running
		lockDrop = !state.lockState;
		clockDrop = state.inState && !next_state.inState;
		lossEvent = (state.mode == HPL_RUN) && (lockDrop || clockDrop || cfgChange);
		// sticky flag, set wins over clear on read
		if (lossEvent) begin
			next_state.flag = 1'b1;
		end else if (unlockRead) begin
			next_state.flag = 1'b0;
		end
	end

	// state register
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= '{lockSync: '0, inSync: '0, refSync: '0, xtalSync: '0, lockState: 1'b0, inState: 1'b0,
				refState: 1'b0, xtalState: 1'b0, flag: 1'b0,
				source: HPL_SRC_OSC, divider: RESET_DIVIDE, drive: 1'b0, enable: 1'b0,
				ratioOut: RESET_RATIO, outEn: 1'b0, lastRatio: 32'h0, lastFormat: 1'b0,
				lastModifier: MOD_NONE, lastDivide: RESET_DIVIDE, lastSource: RESET_SOURCE,
				mode: HPL_OFF};
		end else begin
			state <= next_state;
		end
	end

	// outputs come straight from registers
	assign unlockFlag = state.flag;
	assign activeSource = state.source;
	assign dividerSetting = state.divider;
	assign crystalDrive = state.drive;
	assign loopEnable = state.enable;
	assign loopRatio = state.ratioOut;
	assign outputEnable = state.outEn;
endmodule

/* testbench/hpl_control_sva.sv */
// assertions on the ports of the pll ratio and lock control
`timescale 1ns/10ps
module hpl_control_sva
	import hpl_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic [1:0]  refDivide,
	input wire logic        crystal_drive_gear_one,
	input wire logic        crystal_drive_gear_two,
	input wire logic        crystal_drive_gear_three,
	input wire logic        loop_enable_first,
	input wire logic        loop_enable_second,
	input wire logic        analogLocked,
	input wire logic        unlockRead,
	input wire logic        unlockFlag,
	input wire logic [1:0]  dividerSetting,
	input wire logic        crystalDrive,
	input wire logic        loopEnable,
	input wire logic [39:0] loopRatio,
	input wire logic        outputEnable
);
	logic gearPick;
	logic bothOn;
	assign bothOn = loop_enable_first && loop_enable_second;
	always_comb begin
		case (refDivide)
			DIV_BY_ONE: gearPick = crystal_drive_gear_one;
			DIV_BY_TWO: gearPick = crystal_drive_gear_two;
			DIV_BY_FOUR: gearPick = crystal_drive_gear_three;
			default: gearPick = 1'h0;
		endcase
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	AST_LOOP_ON: assert property (bothOn |=> loopEnable) else $error("loop off with both bits set");
	AST_LOOP_OFF: assert property (!bothOn |=> !loopEnable) else $error("loop on with a bit clear");
	AST_DIVIDER: assert property (1'h1 |=> dividerSetting == $past(refDivide)) else $error("divider wrong");
	AST_GEAR: assert property (1'h1 |=> crystalDrive == $past(gearPick)) else $error("gear drive wrong");
	AST_FLAG_HOLD: assert property (unlockFlag && !unlockRead |=> unlockFlag) else $error("flag lost");
	AST_FLAG_CLEAR: assert property ($fell(unlockFlag) |-> $past(unlockRead)) else $error("flag cleared unread");
	AST_LOSS_SETS: assert property ((loopEnable && outputEnable && !analogLocked)[*5] |=> unlockFlag)
		else $error("loss not flagged");
	AST_ZERO_BLOCKS: assert property ((loopRatio == 40'h0)[*3] |-> !outputEnable) else $error("zero ratio output");
	AST_OFF_BLOCKS: assert property ((!loopEnable)[*3] |-> !outputEnable) else $error("output with loop off");
	cover property (bothOn ##1 loopEnable);
	cover property ($rose(unlockFlag));
	cover property ($fell(outputEnable));
endmodule
bind hpl_control hpl_control_sva i_hpl_control_sva (.clk, .rstn, .refDivide, .crystal_drive_gear_one,
	.crystal_drive_gear_two, .crystal_drive_gear_three, .loop_enable_first, .loop_enable_second, .analogLocked,
	.unlockRead, .unlockFlag, .dividerSetting, .crystalDrive, .loopEnable, .loopRatio, .outputEnable);

/* testbench/hpl_pll_model.sv */
// analog loop and clock input model
`timescale 1ns/10ps
module hpl_pll_model #(
	parameter int LOCK_CYCLES = 6
) (
	input  wire logic clk,
	input  wire logic loopEnable,
	input  wire logic dropLock,
	input  wire logic stopClock,
	output logic      analogLocked,
	output logic      clockInActive
);
	int count = 0;
	// lock comes some cycles after the loop runs with its input clock
	always @(posedge clk) begin
		count <= (loopEnable && !dropLock && !stopClock) ? count + 1 : 0;
	end
	assign analogLocked = count > LOCK_CYCLES;
	assign clockInActive = !stopClock;
endmodule

/* testbench/tb.sv */
// self-checking bench for the pll ratio and lock control
`timescale 1ns/10ps
module tb;
	import hpl_pkg::*;
	logic clk = 0, rstn = 0, refPinTied, crystalPinTied, loop_enable_first, loop_enable_second, ratioFormat;
	logic [1:0] timing_source_select, refDivide, dividerSetting;
	logic [2:0] gear, multiplier_modifier;
	logic [31:0] ratio, rnd = 32'hE549;
	logic unlockRead, dropLock, stopClock, analogLocked, clockInActive, unlockFlag, crystalDrive, loopEnable;
	logic outputEnable;
	logic [39:0] loopRatio;
	hpl_source_type activeSource;
	longint exp;
	int fail_count = 0, checks = 0, cycles = 0;
	always #12.5 clk = !clk;
	hpl_control i_hpl_control (.clk, .rstn, .timing_source_select, .refDivide, .crystal_drive_gear_one(gear[0]),
		.crystal_drive_gear_two(gear[1]), .crystal_drive_gear_three(gear[2]), .refPinTied, .crystalPinTied,
		.loop_enable_first, .loop_enable_second, .ratio, .ratioFormat, .multiplier_modifier, .analogLocked,
		.clockInActive, .unlockRead, .unlockFlag, .activeSource, .dividerSetting, .crystalDrive, .loopEnable,
		.loopRatio, .outputEnable);
	hpl_pll_model i_hpl_pll_model (.clk, .loopEnable, .dropLock, .stopClock, .analogLocked, .clockInActive);
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
	endfunction
	function automatic longint effRatio(input longint raw, input int f, input int m);
		longint a;
		a = f ? raw << 8 : raw;
		a = m == 0 ? a : (m < 4 ? a << m : a >> (m - 3));
		return a & 64'h0000_00FF_FFFF_FFFF;
	endfunction
	function automatic int srcExp(input int s, input int r, input int x);
		if (s == 1 || (s != 2 && r)) return 0;
		return x ? 1 : 2;
	endfunction
	task automatic check(input logic [39:0] seen, input logic [39:0] want);
		checks++;
		if (seen !== want) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, want);
		end
	endtask
	task automatic wrap_up;
		$display("checks %0d fail_count %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(negedge clk);
	endtask
	task automatic readFlag(input logic want);
		check(unlockFlag, want);
		unlockRead = 1;
		tick(1);
		unlockRead = 0;
		tick(1);
	endtask
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			fail_count++;
			wrap_up();
		end
	end
	initial begin
		{timing_source_select, refDivide, gear, refPinTied, crystalPinTied, ratioFormat, multiplier_modifier} = 0;
		{loop_enable_first, loop_enable_second, unlockRead, dropLock, stopClock, ratio} = 0;
		tick(8);
		check(dividerSetting, DIV_BY_ONE);
		check(activeSource, HPL_SRC_OSC);
		rstn = 1;
		for (int i = 0; i < 16; i++) begin
			{timing_source_select, refPinTied, crystalPinTied} = i[3:0];
			refDivide = i[1:0];
			gear = rnd[2:0];
			rnd = lfsr(rnd);
			tick(6);
			check(activeSource, srcExp(timing_source_select, refPinTied, crystalPinTied));
			check(dividerSetting, refDivide);
			check(crystalDrive, refDivide == 3 ? 0 : gear[2 - refDivide]);
		end
		for (int i = 0; i < 4; i++) begin
			{loop_enable_first, loop_enable_second} = i[1:0];
			tick(2);
			check(loopEnable, i == 3);
		end
		for (int i = 0; i < 18; i++) begin
			ratio = i == 16 ? 0 : rnd;
			ratioFormat = i[3];
			multiplier_modifier = i[2:0];
			rnd = lfsr(rnd);
			tick(4);
			exp = effRatio(ratio, ratioFormat, multiplier_modifier);
			check(loopRatio, exp[39:0]);
			check(outputEnable, exp != 0);
		end
		{loop_enable_first, loop_enable_second} = 0;
		refDivide = DIV_BY_ONE;
		ratioFormat = FMT_HIGH_RES;
		multiplier_modifier = MOD_NONE;
		ratio = 32'h0020_0000;
		tick(2);
		{loop_enable_first, loop_enable_second} = 2'h3;
		tick(20);
		readFlag(1);
		readFlag(0);
		dropLock = 1;
		tick(8);
		readFlag(1);
		readFlag(1);
		dropLock = 0;
		tick(20);
		readFlag(1);
		readFlag(0);
		stopClock = 1;
		tick(8);
		stopClock = 0;
		tick(20);
		readFlag(1);
		ratio = 32'h0030_0000;
		tick(6);
		readFlag(1);
		tick(4);
		readFlag(0);
		wrap_up();
	end
endmodule
